// File: ibo_slot_ctrl.sv
// interleaved pcm bus slot control for one framer
// assumes bus clock, frame sync and bus data in arrive asynchronously on pins;
// the local stream bit comes from the receive elastic store on clock_i
// Behaviour
// - bus carries two, four or eight streams at 4.096, 8.192, 16.384 MHz
// - each framer on the bus owns a slot position no other framer has
// - frame sync comes from backplane or from the first-position framer
// - framer waits for its slot after frame sync before driving or sampling
// - channel interleave: one channel per framer in turn, whole frame
// - channel interleave tolerates asynchronous framers; elastic stores absorb slips
// - low-active output enable marks bus-active times
// - frame interleave: one whole frame per framer in turn
// - three-bit slot field, binary, zero is first, seven is eighth
// - control bit enables interleaved operation when one
// - mode bit: zero channel interleave, one frame interleave
// - bus size field 00 two, 01 four, 10 eight, 11 reserved
`timescale 1ns/1ps
`default_nettype none
module ibo_slot_ctrl (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire ibo_pkg::cpu_req_s cpu_req_i,
    output logic [7:0] cpu_rdata_o,
    input wire logic fsync_source_i,
    input wire logic bus_clk_i,
    input wire logic fsync_i,
    output logic fsync_o,
    output logic fsync_oe_o,
    input wire logic bus_data_i,
    output logic bus_data_o,
    output logic bus_data_oe_o,
    output logic bus_drive_enable_n_o,
    input wire logic stream_bit_i,
    output logic stream_pull_o,
    output logic rx_bit_o,
    output logic rx_valid_o
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic bus_clk_s;
    logic fsync_s;
    logic bus_din_s;
    logic bus_clk_d_r;
    logic fsync_d_r;
    logic clk_rise;
    logic clk_fall;
    logic fsync_rise;

    ibo_sync2 #(.WIDTH(3)) u_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .async_i({bus_data_i, fsync_i, bus_clk_i}),
        .sync_o(pins_s)
    );

    assign bus_clk_s = pins_s[0];
    assign fsync_s = pins_s[1];
    assign bus_din_s = pins_s[2];

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            bus_clk_d_r <= 1'b0;
            fsync_d_r <= 1'b0;
        end else begin
            bus_clk_d_r <= bus_clk_s;
            fsync_d_r <= fsync_s;
        end
    end

    assign clk_rise = bus_clk_s & ~bus_clk_d_r;
    assign clk_fall = ~bus_clk_s & bus_clk_d_r;
    assign fsync_rise = fsync_s & ~fsync_d_r;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    ibo_pkg::ibo_ctrl_s ctrl_r;
    logic reg_hit;

    assign reg_hit = (cpu_req_i.addr == ibo_pkg::TX_INTERLEAVE_BUS_CONTROL_OFS);

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ctrl_r <= ibo_pkg::ibo_ctrl_s'(ibo_pkg::TX_INTERLEAVE_BUS_CONTROL_RST[6:0]);
        end else if (cpu_req_i.wr && reg_hit) begin
            // top bit is not stored; it reads back as zero
            ctrl_r <= ibo_pkg::ibo_ctrl_s'(cpu_req_i.wdata[6:0]);
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cpu_rdata_o <= 8'h00;
        end else if (cpu_req_i.rd) begin
            cpu_rdata_o <= reg_hit ? {1'b0, ctrl_r} : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    logic [10:0] last_bit;
    logic [2:0] slot_mask;
    logic size_ok;

    always_comb begin
        last_bit = ibo_pkg::LAST_BIT_2;
        slot_mask = ibo_pkg::SLOT_MASK_2;
        size_ok = 1'b1;
        case (ctrl_r.bus_size_sel)
            ibo_pkg::BUS_SIZE_2: begin
                last_bit = ibo_pkg::LAST_BIT_2;
                slot_mask = ibo_pkg::SLOT_MASK_2;
            end
            ibo_pkg::BUS_SIZE_4: begin
                last_bit = ibo_pkg::LAST_BIT_4;
                slot_mask = ibo_pkg::SLOT_MASK_4;
            end
            ibo_pkg::BUS_SIZE_8: begin
                last_bit = ibo_pkg::LAST_BIT_8;
                slot_mask = ibo_pkg::SLOT_MASK_8;
            end
            default: begin
                // reserved code keeps the framer off the bus
                size_ok = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // bit position within the bus frame
    // ----------------------------------------------------------------
    logic [10:0] bit_cnt_r;
    logic run;

    assign run = ctrl_r.interleave_on & size_ok;

    // each frame sync realigns the count unless fsync_source_i is set, so a slipping framer only ever
    // loses or repeats whole frames inside its elastic store
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            bit_cnt_r <= 11'h000;
        end else if (!run) begin
            bit_cnt_r <= 11'h000;
        end else if (!fsync_source_i && fsync_rise) begin
            bit_cnt_r <= 11'h000;
        end else if (clk_rise) begin
            bit_cnt_r <= (bit_cnt_r >= last_bit) ? 11'h000 : bit_cnt_r + 11'h001;
        end
    end

    // ----------------------------------------------------------------
    // slot decode
    // ----------------------------------------------------------------
    logic [2:0] cur_slot;
    logic my_slot;

    always_comb begin
        if (ctrl_r.interleave_type_sel == ibo_pkg::FRAME_INTERLEAVE) begin
            cur_slot = bit_cnt_r[ibo_pkg::FRAME_SHIFT +: 3] & slot_mask;
        end else begin
            cur_slot = bit_cnt_r[ibo_pkg::CHAN_SHIFT +: 3] & slot_mask;
        end
    end

    // a position equal to no slot value simply never drives
    assign my_slot = run && (cur_slot == ctrl_r.slot_position_sel);

    // ----------------------------------------------------------------
    // bus drive, output enable and local stream pull
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            bus_drive_enable_n_o <= 1'b1;
            bus_data_oe_o <= 1'b0;
            bus_data_o <= 1'b0;
            stream_pull_o <= 1'b0;
        end else if (!run) begin
            bus_drive_enable_n_o <= 1'b1;
            bus_data_oe_o <= 1'b0;
            bus_data_o <= 1'b0;
            stream_pull_o <= 1'b0;
        end else begin
            stream_pull_o <= clk_rise && my_slot;
            if (clk_rise) begin
                bus_drive_enable_n_o <= ~my_slot;
                bus_data_oe_o <= my_slot;
                bus_data_o <= my_slot ? stream_bit_i : 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // sampling of the shared bus in our own slot
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rx_bit_o <= 1'b0;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= clk_fall && !bus_drive_enable_n_o && run;
            if (clk_fall && !bus_drive_enable_n_o && run) begin
                rx_bit_o <= bus_din_s;
            end
        end
    end

    // ----------------------------------------------------------------
    // frame sync generation for the first-position source
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            fsync_oe_o <= 1'b0;
            fsync_o <= 1'b0;
        end else begin
            fsync_oe_o <= run && fsync_source_i;
            if (!(run && fsync_source_i)) begin
                fsync_o <= 1'b0;
            end else if (clk_rise) begin
                fsync_o <= (bit_cnt_r == 11'h000);
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_OE_OFF_DISABLED: assert property (@(posedge clock_i) disable iff (srst_i)
        !ctrl_r.interleave_on |=> bus_drive_enable_n_o && !bus_data_oe_o)
        else $error("bus enable active while interleave is off");

    AST_OE_PAIR: assert property (@(posedge clock_i) disable iff (srst_i)
        bus_drive_enable_n_o == !bus_data_oe_o)
        else $error("output enable and drive disagree");

    AST_CHAN_SLOT: assert property (@(posedge clock_i) disable iff (srst_i)
        (clk_rise && run && ctrl_r.interleave_type_sel == ibo_pkg::CHANNEL_INTERLEAVE)
        |=> (!bus_drive_enable_n_o ==
             ((($past(bit_cnt_r) >> 3) & 11'($past(slot_mask)))
              == 11'($past(ctrl_r.slot_position_sel)))))
        else $error("channel slot drive mismatch");

    AST_FRAME_SLOT: assert property (@(posedge clock_i) disable iff (srst_i)
        (clk_rise && run && ctrl_r.interleave_type_sel == ibo_pkg::FRAME_INTERLEAVE)
        |=> (!bus_drive_enable_n_o ==
             ((($past(bit_cnt_r) >> 8) & 11'($past(slot_mask)))
              == 11'($past(ctrl_r.slot_position_sel)))))
        else $error("frame slot drive mismatch");

    AST_WRITE_FIELDS: assert property (@(posedge clock_i) disable iff (srst_i)
        (cpu_req_i.wr && reg_hit) |=>
        ctrl_r.slot_position_sel == $past(cpu_req_i.wdata[2:0])
        && ctrl_r.interleave_on == $past(cpu_req_i.wdata[3])
        && ctrl_r.bus_size_sel == $past(cpu_req_i.wdata[6:5]))
        else $error("control write not stored");

    AST_TYPE_BIT: assert property (@(posedge clock_i) disable iff (srst_i)
        (cpu_req_i.wr && reg_hit) |=>
        (ctrl_r.interleave_type_sel == ibo_pkg::FRAME_INTERLEAVE) == $past(cpu_req_i.wdata[4]))
        else $error("interleave type bit not stored");

    AST_SIZE_RSVD: assert property (@(posedge clock_i) disable iff (srst_i)
        (ctrl_r.bus_size_sel == ibo_pkg::BUS_SIZE_RSVD) [*2] |-> bus_drive_enable_n_o)
        else $error("reserved bus size drives the bus");

    AST_CNT_RANGE: assert property (@(posedge clock_i) disable iff (srst_i)
        run |-> bit_cnt_r <= ibo_pkg::LAST_BIT_8)
        else $error("bit count outside bus frame");

    AST_CNT_WRAP: assert property (@(posedge clock_i) disable iff (srst_i)
        (run && clk_rise && bit_cnt_r == last_bit && !(fsync_rise && !fsync_source_i))
        |=> bit_cnt_r == 11'h000)
        else $error("bit count did not wrap at end of bus frame");

    AST_FSYNC_DRIVER: assert property (@(posedge clock_i) disable iff (srst_i)
        fsync_oe_o |-> $past(fsync_source_i) && $past(run))
        else $error("frame sync driven by non-source");

    AST_ON_BIT: assert property (@(posedge clock_i) disable iff (srst_i)
        $rose(run) |-> bit_cnt_r == 11'h000 ##1 bus_drive_enable_n_o || !$past(clk_rise))
        else $error("enable did not start from bit zero");
endmodule : ibo_slot_ctrl
`default_nettype wire

// File: ibo_pkg.sv
// shared constants and types of the interleaved pcm bus slot control
// assumes a single 200 MHz system clock domain inside the framer
package ibo_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] TX_INTERLEAVE_BUS_CONTROL_OFS = 12'h188;
    localparam logic [7:0] TX_INTERLEAVE_BUS_CONTROL_RST = 8'h00;
    localparam int SLOT_POSITION_LSB = 0;
    localparam int INTERLEAVE_ON_BIT = 3;
    localparam int INTERLEAVE_TYPE_BIT = 4;
    localparam int BUS_SIZE_LSB = 5;

    // ----------------------------------------------------------------
    // bus size codes and rates
    // ----------------------------------------------------------------
    localparam logic [1:0] BUS_SIZE_2 = 2'h0;
    localparam logic [1:0] BUS_SIZE_4 = 2'h1;
    localparam logic [1:0] BUS_SIZE_8 = 2'h2;
    localparam logic [1:0] BUS_SIZE_RSVD = 2'h3;
    localparam int BUS_RATE_2_KHZ = 4096;
    localparam int BUS_RATE_4_KHZ = 8192;
    localparam int BUS_RATE_8_KHZ = 16384;
    localparam int FSYNC_RATE_KHZ = 8;
    // bits of one stream per 125 us frame
    localparam int STREAM_FRAME_BITS = BUS_RATE_2_KHZ / FSYNC_RATE_KHZ / 2;
    localparam logic [10:0] LAST_BIT_2 = 11'(BUS_RATE_2_KHZ / FSYNC_RATE_KHZ - 1);
    localparam logic [10:0] LAST_BIT_4 = 11'(BUS_RATE_4_KHZ / FSYNC_RATE_KHZ - 1);
    localparam logic [10:0] LAST_BIT_8 = 11'(BUS_RATE_8_KHZ / FSYNC_RATE_KHZ - 1);
    localparam logic [2:0] SLOT_MASK_2 = 3'h1;
    localparam logic [2:0] SLOT_MASK_4 = 3'h3;
    localparam logic [2:0] SLOT_MASK_8 = 3'h7;
    localparam int CHAN_SHIFT = 3;
    localparam int FRAME_SHIFT = 8;

    typedef enum logic {
        CHANNEL_INTERLEAVE = 1'b0,
        FRAME_INTERLEAVE = 1'b1
    } interleave_type_e;

    typedef struct packed {
        logic [1:0] bus_size_sel;
        interleave_type_e interleave_type_sel;
        logic interleave_on;
        logic [2:0] slot_position_sel;
    } ibo_ctrl_s;

    typedef struct packed {
        logic [11:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } cpu_req_s;

endpackage : ibo_pkg

// File: ibo_sync2.sv
// two-flop synchroniser for pins from outside the system clock domain
// assumes each bit is a slow level; no bus coherency between bits
`timescale 1ns/1ps
`default_nettype none
module ibo_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : ibo_sync2
`default_nettype wire

// File: ibo_backplane_model.sv
// backplane timing source: free bus clock, frame sync, other framers' data
// assumes the bench requests a frame sync through sync_req_i
`timescale 1ns/1ps
`default_nettype none
module ibo_backplane_model (
    input wire logic sync_req_i,
    output logic bus_clk_o,
    output logic fsync_o,
    output logic bus_data_o,
    output logic [10:0] bit_idx_o
);
    // ----------------------------------------------------------------
    // bus clock, 160 ns, free running
    // ----------------------------------------------------------------
    initial begin
        bus_clk_o = 1'b0;
        fsync_o = 1'b0;
        bus_data_o = 1'b0;
        bit_idx_o = 11'h000;
        forever #80 bus_clk_o = ~bus_clk_o;
    end
    // sync raised on a fall so bit 0 starts at the next rise
    always @(negedge bus_clk_o) begin
        fsync_o <= sync_req_i && !fsync_o;
    end
    // each bit after bit 0 differs from the last, so a stale sample shows
    always @(posedge bus_clk_o) begin
        bit_idx_o <= fsync_o ? 11'h000 : bit_idx_o + 11'h001;
        bus_data_o <= fsync_o ? 1'b0 : ~bit_idx_o[0];
    end
endmodule : ibo_backplane_model
`default_nettype wire

// File: interleaved_pcm_bus_slot_control_bench.sv
// self-checking bench of the interleaved bus slot control
// assumes the backplane model supplies bus clock, frame sync and data in
`timescale 1ns/1ps
`default_nettype none
module interleaved_pcm_bus_slot_control_bench;
    logic clock_i;
    logic srst_i;
    ibo_pkg::cpu_req_s cpu_req;
    logic [7:0] rdata;
    logic fsync_source;
    logic bus_clk;
    logic bclk_q;
    logic bp_fsync;
    logic bp_data;
    logic fs_pin;
    logic fsync_o;
    logic fsync_oe_o;
    logic bus_data_o;
    logic bus_data_oe_o;
    logic bus_drive_enable_n_o;
    logic stream_bit;
    logic pulled;
    logic stream_pull_o;
    logic rx_bit_o;
    logic rx_valid_o;
    logic sync_req;
    logic [10:0] bit_idx;
    int n_mismatch;
    int samples_checked;
    int n_pull;
    int n_rx;
    localparam logic [11:0] OFS = ibo_pkg::TX_INTERLEAVE_BUS_CONTROL_OFS;

    // only one party drives frame sync
    assign fs_pin = fsync_oe_o ? fsync_o : bp_fsync;

    ibo_backplane_model bp (.sync_req_i(sync_req), .bus_clk_o(bus_clk),
        .fsync_o(bp_fsync), .bus_data_o(bp_data), .bit_idx_o(bit_idx));

    ibo_slot_ctrl DUT (.clock_i(clock_i), .srst_i(srst_i), .cpu_req_i(cpu_req),
        .cpu_rdata_o(rdata), .fsync_source_i(fsync_source), .bus_clk_i(bus_clk),
        .fsync_i(fs_pin), .fsync_o(fsync_o), .fsync_oe_o(fsync_oe_o),
        .bus_data_i(bp_data), .bus_data_o(bus_data_o), .bus_data_oe_o(bus_data_oe_o),
        .bus_drive_enable_n_o(bus_drive_enable_n_o), .stream_bit_i(stream_bit),
        .stream_pull_o(stream_pull_o), .rx_bit_o(rx_bit_o), .rx_valid_o(rx_valid_o));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic finish_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        cpu_req.addr = a;
        cpu_req.wdata = d;
        cpu_req.wr = 1'b1;
        @(posedge clock_i);
        #1 cpu_req.wr = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [11:0] a, input logic [7:0] e);
        cpu_req.addr = a;
        cpu_req.rd = 1'b1;
        @(posedge clock_i);
        #1 cpu_req.rd = 1'b0;
        @(posedge clock_i);
        #1 chk("rdata", e, rdata);
    endtask : reg_rd

    // bounded wait for a bus clock fall seen by the system clock
    task automatic bus_fall();
        int n;
        for (n = 0; n < 64; n++) begin
            @(posedge clock_i);
            if (bclk_q && !bus_clk) break;
        end
        if (n == 64) begin
            n_mismatch++;
            finish_test();
        end
        #1;
    endtask : bus_fall

    function automatic logic exp_act(input logic [7:0] c, input logic [10:0] b);
        logic [2:0] m;
        logic [2:0] s;
        m = (c[6:5] == 2'h0) ? 3'h1 : ((c[6:5] == 2'h1) ? 3'h3 : 3'h7);
        s = (c[4] ? b[10:8] : b[5:3]) & m;
        return c[3] && (c[6:5] != 2'h3) && (s == c[2:0]);
    endfunction : exp_act

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic reg_test();
        reg_rd(OFS, 8'h00);
        reg_wr(OFS, 8'hFF);
        reg_rd(OFS, 8'h7F);
        reg_wr(12'h189, 8'h00);
        reg_rd(OFS, 8'h7F);
        reg_rd(12'h189, 8'h00);
    endtask : reg_test

    task automatic source_test();
        int n;
        reg_wr(OFS, 8'h08);
        fsync_source = 1'b1;
        repeat (4) @(posedge clock_i);
        #1 chk("fsync_oe", 8'h01, {7'h00, fsync_oe_o});
        // every fsync_o look below is just after a bus clock fall
        bus_fall();
        for (n = 0; n < 600 && fsync_o !== 1'b1; n++) begin
            bus_fall();
        end
        chk("fsync_pulse", 8'h01, {7'h00, fsync_o});
        bus_fall();
        chk("fsync_width", 8'h00, {7'h00, fsync_o});
        for (n = 1; n < 600 && fsync_o !== 1'b1; n++) begin
            bus_fall();
        end
        chk("fsync_period_hi", 8'((int'(ibo_pkg::LAST_BIT_2) + 1) >> 8), 8'(n >> 8));
        chk("fsync_period_lo", 8'(int'(ibo_pkg::LAST_BIT_2) + 1), 8'(n));
        fsync_source = 1'b0;
        repeat (4) @(posedge clock_i);
        #1 chk("fsync_oe", 8'h00, {7'h00, fsync_oe_o});
    endtask : source_test

    // sample every bus bit in mid-period against the slot map
    task automatic run_bus(input logic [7:0] ctrl, input int nbits);
        logic act;
        int n_act;
        reg_wr(OFS, ctrl);
        // raise the request just after a fall so the next fall takes it
        bus_fall();
        sync_req = 1'b1;
        bus_fall();
        sync_req = 1'b0;
        repeat (8) @(posedge clock_i);
        #1 n_pull = 0;
        n_rx = 0;
        n_act = 0;
        repeat (nbits) begin
            bus_fall();
            act = exp_act(ctrl, bit_idx);
            if (act) n_act++;
            chk("drive_en_n", {7'h00, !act}, {7'h00, bus_drive_enable_n_o});
            chk("data_oe", {7'h00, act}, {7'h00, bus_data_oe_o});
            if (act) chk("bus_data", {7'h00, pulled}, {7'h00, bus_data_o});
        end
        repeat (8) @(posedge clock_i);
        #1 chk("pulls", 8'(n_act), 8'(n_pull));
        chk("rx_count", 8'(n_act), 8'(n_rx));
    endtask : run_bus

    // mid-run reset drops the bus and clears the control word
    task automatic reset_test();
        srst_i = 1'b1;
        repeat (4) @(posedge clock_i);
        #1 srst_i = 1'b0;
        chk("rst_drive_en_n", 8'h01, {7'h00, bus_drive_enable_n_o});
        reg_rd(OFS, 8'h00);
    endtask : reset_test

    // receive side: a sample only inside our slot, with that bit's value
    always @(posedge clock_i) begin
        bclk_q <= bus_clk;
        if (rx_valid_o === 1'b1) begin
            chk("rx_bit", {7'h00, bit_idx[0]}, {7'h00, rx_bit_o});
            chk("rx_slot", 8'h00, {7'h00, bus_drive_enable_n_o});
            n_rx <= n_rx + 1;
        end
    end

    // elastic store stand-in: next bit presented after each pull
    always @(posedge clock_i) begin
        if (stream_pull_o === 1'b1) begin
            pulled <= stream_bit;
            stream_bit <= #1 ~stream_bit;
            n_pull <= n_pull + 1;
        end
    end

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    initial begin
        srst_i = 1'b1;
        cpu_req = '0;
        fsync_source = 1'b0;
        stream_bit = 1'b0;
        pulled = 1'b0;
        bclk_q = 1'b0;
        sync_req = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        n_pull = 0;
        n_rx = 0;
        repeat (16) @(posedge clock_i);
        #1 srst_i = 1'b0;
        reg_test();
        source_test();
        run_bus(8'h08, 24);
        reset_test();
        run_bus(8'h29, 40);
        run_bus(8'h4F, 72);
        run_bus(8'h19, 264);
        run_bus(8'h0B, 32);
        run_bus(8'h68, 16);
        run_bus(8'h00, 16);
        finish_test();
    end
endmodule : interleaved_pcm_bus_slot_control_bench
`default_nettype wire
